/* File: countdown_timer.sv */
/*
  one microsecond countdown timer; a zero value never starts it.
  assumes a one-cycle tick every microsecond; start wins over stop.
*/
module countdown_timer
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // time base
  input wire logic tick,
  // control
  timer_if.tmr tif
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [31:0] cnt_q;
  logic run_q;
  logic exp_q;
  logic fire;

  // one extra tick so the least time is never cut short
  assign fire = run_q && tick && (cnt_q == 32'h0000_0000);
  assign tif.expired = exp_q;
  assign tif.running = run_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= 32'h0000_0000;
      run_q <= 1'b0;
      exp_q <= 1'b0;
    end
    else
    begin
      exp_q <= fire && !tif.start && !tif.stop;
      if (tif.start)
      begin
        cnt_q <= tif.value;
        run_q <= (tif.value != 32'h0000_0000);
      end
      else if (tif.stop || fire)
        run_q <= 1'b0;
      else if (run_q && tick)
        cnt_q <= cnt_q - 32'h0000_0001;
    end
  end

endmodule : countdown_timer

/* File: link_peer.sv */
/*
  remote master station model driving the link event pulses.
  assumes its tasks are called right after a rising aclk edge.
*/
module link_peer
#(
  parameter int BREAK_CYC = 16
)
(
  // clock
  input wire logic aclk,
  // from slave
  input wire logic keepalive_req,
  // to slave
  output logic [10:0] ev,
  output logic [15:0] len
);
  timeunit 1ns;
  timeprecision 100ps;
  int ka_cnt;

  initial
  begin
    ev = '0;
    len = 16'h000A;
    ka_cnt = 0;
  end

  // count each keep-alive request seen from the slave
  always @(posedge aclk)
  begin
    if (keepalive_req === 1'h1) ka_cnt <= ka_cnt + 1;
  end

  task automatic pulse(input int i);
    ev[i] <= 1'h1;
    @(posedge aclk);
    ev[i] <= 1'h0;
    @(posedge aclk);
  endtask : pulse

  // break delay before attach
  task automatic attach();
    repeat (BREAK_CYC) @(posedge aclk);
    pulse(0);
  endtask : attach
endmodule : link_peer

/* File: serial_link_timer_supervisor.sv */
/*
  link supervision timers for a half-duplex master/slave serial station, slave
  side: idle, acknowledgement, processing and buffer message timers, derived
  timer values, axi4-lite register slave and interrupt.
  assumes link event inputs are one-cycle pulses synchronous to aclk.
*/
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
// Behaviour
// - after attach use attach idle value until first message received
// - attach idle value is configured idle plus 65 s; off when idle off
// - processing timer starts on final ack; expiry sends keep-alive
// - processing time from configuration, zero disables, at most 5 s
// - processing time is never negotiated; own configured value used
// - processing timer disabled whenever acknowledgement timeout is disabled
// - buffer timeout starts when another buffer is expected; aborts on expiry
// - buffer timeout is master timeout plus delay plus two buffer times
// - turnaround from configuration, zero means none, at most 500 ms
// - transmission delay defaults to 0 ms; negotiated takes the larger
// - idle timer starts after response, cancelled by request, aborts on expiry
// - abort when no acknowledgement arrives within the acknowledgement timeout
module serial_link_timer_supervisor
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // link events
  input wire logic attach_done,
  input wire logic msg_rx,
  input wire logic req_rx,
  input wire logic line_activity,
  input wire logic resp_done,
  input wire logic msg_tx,
  input wire logic ack_rx,
  input wire logic final_ack_tx,
  input wire logic resp_ready,
  input wire logic buf_expect,
  input wire logic buf_rx,
  input wire logic [15:0] buf_len,
  // link actions
  output logic keepalive_req,
  output logic abort_req,
  // interrupt
  output logic irq
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0] cfg_q [timer_pkg::NUM_CFG];
  logic [3:0] status_q;
  logic [3:0] mask_q;
  logic attach_mode_q;
  logic aw_held_q;
  logic [7:0] aw_addr_q;
  logic w_held_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic keepalive_q;
  logic abort_q;
  logic irq_q;

  // ----------------------------------------------------------------
  // timer instances
  // ----------------------------------------------------------------
  logic tick;
  logic [3:0] start_w;
  logic [3:0] stop_w;
  logic [31:0] value_w [timer_pkg::NUM_TMR];
  logic [3:0] expired_w;
  logic [3:0] running_w;

  us_tick u_tick
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick)
  );

  timer_if tmr [timer_pkg::NUM_TMR] ();

  genvar gi;
  generate
    for (gi = 0; gi < timer_pkg::NUM_TMR; gi++)
    begin : g_tmr
      assign tmr[gi].start = start_w[gi];
      assign tmr[gi].stop = stop_w[gi];
      assign tmr[gi].value = value_w[gi];
      assign expired_w[gi] = tmr[gi].expired;
      assign running_w[gi] = tmr[gi].running;
      countdown_timer u_cd
      (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .tif(tmr[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // effective values, milliseconds then microseconds
  // ----------------------------------------------------------------
  logic neg;
  logic [31:0] turn_own;
  logic [31:0] turn_peer;
  logic [31:0] turn_ms;
  logic [31:0] xmit_ms;
  logic [31:0] idle_ms;
  logic [31:0] ack_ms;
  logic [31:0] proc_ms;
  logic [31:0] turn_us;
  logic [31:0] xmit_us;
  logic [31:0] idle_us;
  logic [31:0] attach_us;
  logic [31:0] ack_us;
  logic [31:0] proc_us;
  logic [31:0] char80_us;
  logic [31:0] mpt_us;
  logic [31:0] bufx_us;
  logic [31:0] buf_us;

  assign neg = cfg_q[timer_pkg::CFG_CTRL][timer_pkg::CTRL_NEG_BIT];
  assign turn_own = (cfg_q[timer_pkg::CFG_TURN] > timer_pkg::TURN_MAX_MS) ?
    timer_pkg::TURN_MAX_MS : cfg_q[timer_pkg::CFG_TURN];
  assign turn_peer = (cfg_q[timer_pkg::CFG_PEER_TURN] > timer_pkg::TURN_MAX_MS) ?
    timer_pkg::TURN_MAX_MS : cfg_q[timer_pkg::CFG_PEER_TURN];
  assign turn_ms = (neg && turn_peer > turn_own) ? turn_peer : turn_own;
  assign xmit_ms = (neg && cfg_q[timer_pkg::CFG_PEER_XMIT] > cfg_q[timer_pkg::CFG_XMIT]) ?
    cfg_q[timer_pkg::CFG_PEER_XMIT] : cfg_q[timer_pkg::CFG_XMIT];
  assign idle_ms = (neg && cfg_q[timer_pkg::CFG_PEER_IDLE] > cfg_q[timer_pkg::CFG_IDLE]) ?
    cfg_q[timer_pkg::CFG_PEER_IDLE] : cfg_q[timer_pkg::CFG_IDLE];
  assign ack_ms = (neg && cfg_q[timer_pkg::CFG_PEER_ACK] > cfg_q[timer_pkg::CFG_ACK]) ?
    cfg_q[timer_pkg::CFG_PEER_ACK] : cfg_q[timer_pkg::CFG_ACK];
  // own value only, never the peer's
  assign proc_ms = (cfg_q[timer_pkg::CFG_PROC] > timer_pkg::PROC_MAX_MS) ?
    timer_pkg::PROC_MAX_MS : cfg_q[timer_pkg::CFG_PROC];

  assign turn_us = turn_ms * timer_pkg::US_PER_MS;
  assign xmit_us = xmit_ms * timer_pkg::US_PER_MS;
  assign idle_us = (idle_ms == 32'h0000_0000) ? 32'h0000_0000 :
    idle_ms * timer_pkg::US_PER_MS + turn_us;
  assign attach_us = (cfg_q[timer_pkg::CFG_IDLE] == 32'h0000_0000) ? 32'h0000_0000 :
    cfg_q[timer_pkg::CFG_IDLE] * timer_pkg::US_PER_MS + timer_pkg::ATTACH_EXTRA_US;
  assign ack_us = (ack_ms == 32'h0000_0000) ? 32'h0000_0000 :
    ack_ms * timer_pkg::US_PER_MS + turn_us + xmit_us;
  assign proc_us = (ack_ms == 32'h0000_0000) ? 32'h0000_0000 :
    proc_ms * timer_pkg::US_PER_MS;
  assign char80_us = cfg_q[timer_pkg::CFG_CHAR] * timer_pkg::MPT_CHARS;
  assign mpt_us = (proc_us == 32'h0000_0000) ? 32'h0000_0000 :
    proc_us + char80_us + turn_us;
  assign bufx_us = ({16'h0000, buf_len} * cfg_q[timer_pkg::CFG_CHAR]) << 1;
  assign buf_us = (mpt_us == 32'h0000_0000) ? 32'h0000_0000 :
    mpt_us + xmit_us + bufx_us;

  // ----------------------------------------------------------------
  // timer control
  // ----------------------------------------------------------------
  assign start_w[timer_pkg::T_IDLE] = resp_done || attach_done ||
    (line_activity && running_w[timer_pkg::T_IDLE]);
  assign stop_w[timer_pkg::T_IDLE] = req_rx;
  assign value_w[timer_pkg::T_IDLE] = (attach_mode_q || attach_done) ?
    attach_us : idle_us;

  assign start_w[timer_pkg::T_ACK] = msg_tx;
  assign stop_w[timer_pkg::T_ACK] = ack_rx;
  assign value_w[timer_pkg::T_ACK] = ack_us;

  // keep-alive restarts the processing timer
  assign start_w[timer_pkg::T_PROC] = final_ack_tx || expired_w[timer_pkg::T_PROC];
  assign stop_w[timer_pkg::T_PROC] = resp_ready;
  assign value_w[timer_pkg::T_PROC] = proc_us;

  assign start_w[timer_pkg::T_BUF] = buf_expect;
  assign stop_w[timer_pkg::T_BUF] = buf_rx;
  assign value_w[timer_pkg::T_BUF] = buf_us;

  logic abort_ev;
  assign abort_ev = expired_w[timer_pkg::T_IDLE] || expired_w[timer_pkg::T_ACK] ||
    expired_w[timer_pkg::T_BUF];

  // ----------------------------------------------------------------
  // axi4-lite decode
  // ----------------------------------------------------------------
  logic aw_take;
  logic w_take;
  logic do_write;
  logic ar_take;
  logic aw_held_d;
  logic w_held_d;
  logic rvalid_d;
  logic wr_cfg;
  logic wr_status;
  logic wr_mask;
  logic rd_cfg;
  logic rd_ok;
  logic [31:0] wmask;
  logic [31:0] wmerge_cfg [timer_pkg::NUM_CFG];
  logic [31:0] rd_word;
  logic [3:0] status_d;

  assign aw_take = s_axi_awvalid && awready_q;
  assign w_take = s_axi_wvalid && wready_q;
  assign do_write = aw_held_q && w_held_q && !bvalid_q;
  assign ar_take = s_axi_arvalid && arready_q;
  assign aw_held_d = aw_take || (aw_held_q && !do_write);
  assign w_held_d = w_take || (w_held_q && !do_write);
  assign rvalid_d = ar_take || (rvalid_q && !s_axi_rready);
  assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  assign wr_cfg = aw_addr_q[7:2] < 6'(timer_pkg::NUM_CFG) && aw_addr_q[1:0] == 2'h0;
  assign wr_status = aw_addr_q == timer_pkg::ADDR_STATUS;
  assign wr_mask = aw_addr_q == timer_pkg::ADDR_MASK;
  assign rd_cfg = s_axi_araddr[7:2] < 6'(timer_pkg::NUM_CFG) && s_axi_araddr[1:0] == 2'h0;
  assign rd_ok = rd_cfg || s_axi_araddr == timer_pkg::ADDR_STATUS ||
    s_axi_araddr == timer_pkg::ADDR_MASK || s_axi_araddr == timer_pkg::ADDR_MPT ||
    s_axi_araddr == timer_pkg::ADDR_BUF || s_axi_araddr == timer_pkg::ADDR_STATE;
  assign rd_word = rd_cfg ? cfg_q[s_axi_araddr[5:2]] :
    (s_axi_araddr == timer_pkg::ADDR_STATUS) ? {28'h000_0000, status_q} :
    (s_axi_araddr == timer_pkg::ADDR_MASK) ? {28'h000_0000, mask_q} :
    (s_axi_araddr == timer_pkg::ADDR_MPT) ? mpt_us :
    (s_axi_araddr == timer_pkg::ADDR_BUF) ? buf_us :
    (s_axi_araddr == timer_pkg::ADDR_STATE) ? {27'h000_0000, attach_mode_q, running_w} :
    32'h0000_0000;

  // set wins over a write-one clear
  assign status_d = (status_q & ~((do_write && wr_status) ? w_data_q[3:0] & wmask[3:0] :
    4'h0)) | expired_w;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  generate
    for (gi = 0; gi < timer_pkg::NUM_CFG; gi++)
    begin : g_cfg
      assign wmerge_cfg[gi] = (cfg_q[gi] & ~wmask) | (w_data_q & wmask);
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          cfg_q[gi] <= timer_pkg::CFG_RST[gi];
        else if (do_write && wr_cfg && aw_addr_q[5:2] == 4'(gi))
          cfg_q[gi] <= wmerge_cfg[gi];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // bus channels
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= timer_pkg::RESP_OKAY;
    end
    else
    begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awready_q <= !aw_held_d;
      wready_q <= !w_held_d;
      if (aw_take)
        aw_addr_q <= s_axi_awaddr;
      if (w_take)
      begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= (wr_cfg || wr_status || wr_mask) ? timer_pkg::RESP_OKAY :
          timer_pkg::RESP_DECERR;
      end
      else if (s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= timer_pkg::RESP_OKAY;
    end
    else
    begin
      rvalid_q <= rvalid_d;
      arready_q <= !rvalid_d;
      if (ar_take)
      begin
        rdata_q <= rd_word;
        rresp_q <= rd_ok ? timer_pkg::RESP_OKAY : timer_pkg::RESP_DECERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // link state, status and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      attach_mode_q <= 1'b0;
      status_q <= 4'h0;
      mask_q <= 4'h0;
      keepalive_q <= 1'b0;
      abort_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      if (attach_done)
        attach_mode_q <= 1'b1;
      else if (msg_rx)
        attach_mode_q <= 1'b0;
      status_q <= status_d;
      if (do_write && wr_mask)
        mask_q <= (mask_q & ~wmask[3:0]) | (w_data_q[3:0] & wmask[3:0]);
      keepalive_q <= expired_w[timer_pkg::T_PROC];
      abort_q <= abort_ev;
      irq_q <= |(status_d & mask_q);
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign keepalive_req = keepalive_q;
  assign abort_req = abort_q;
  assign irq = irq_q;

endmodule : serial_link_timer_supervisor

/* File: tb.sv */
/*
  self-checking bench for the link timer supervisor.
  assumes the checker binds itself and link_peer drives link events.
*/
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} row_t;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] strb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, keep, abort, irq;
  logic [1:0] bresp, rresp, r, br;
  logic [31:0] rdata, d, s;
  logic [10:0] ev;
  logic [15:0] len;
  int n;
  int failures = 0;
  int n_checks = 0;
  row_t rows [14] = '{'{8'h00, 32'h0000_2710, 2'h0}, '{8'h04, 32'h0000_07D0, 2'h0},
    '{8'h08, 32'h0000_1388, 2'h0}, '{8'h0C, 32'h0000_0000, 2'h0}, '{8'h10, 32'h0000_0000, 2'h0},
    '{8'h14, 32'h0000_0412, 2'h0}, '{8'h18, 32'h0000_0032, 2'h0}, '{8'h1C, 32'h0000_0000, 2'h0},
    '{8'h2C, 32'h0000_0000, 2'h0}, '{8'h30, 32'h0000_0000, 2'h0}, '{8'h34, 32'h0000_0000, 2'h0},
    '{8'h38, 32'h004D_90E0, 2'h0}, '{8'h44, 32'h0000_0000, 2'h3}, '{8'h02, 32'h0000_0000, 2'h3}};

  always #2.5 aclk = ~aclk;

  serial_link_timer_supervisor dut
  (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .attach_done(ev[0]), .msg_rx(ev[1]), .req_rx(ev[2]), .line_activity(ev[3]),
    .resp_done(ev[4]), .msg_tx(ev[5]), .ack_rx(ev[6]), .final_ack_tx(ev[7]),
    .resp_ready(ev[8]), .buf_expect(ev[9]), .buf_rx(ev[10]), .buf_len(len),
    .keepalive_req(keep), .abort_req(abort), .irq(irq)
  );

  link_peer peer (.aclk(aclk), .keepalive_req(keep), .ev(ev), .len(len));

  // ----
  // bus, wait and report tasks
  // ----
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end
    while (bvalid !== 1'h1);
    bready <= 1'h1;
    @(posedge aclk);
    br = bresp;
    bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (arready === 1'h1) arvalid <= 1'h0;
    end
    while (rvalid !== 1'h1);
    rready <= 1'h1;
    @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask : rd

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(d, e)
  endtask : chk_rd

  task automatic wait_abort();
    n = 0;
    while (n < 2200 && abort !== 1'h1)
    begin
      @(posedge aclk);
      n++;
    end
  endtask : wait_abort

  task automatic final_report();
    if (failures == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  // value whose microsecond product wraps to 8
  function automatic logic [31:0] inv8();
    logic [31:0] x;
    x = 32'h0000_007D;
    repeat (5) x = x * (32'h0000_0002 - 32'h0000_007D * x);
    return x;
  endfunction : inv8

  initial
  begin
    repeat (60000) @(posedge aclk);
    failures++;
    final_report();
  end

  initial
  begin
    s = inv8();
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    foreach (rows[i])
    begin
      rd(rows[i].a);
      `CHK({r, d}, {rows[i].r, rows[i].d})
    end
    wr(8'h04, s);
    peer.pulse(5);
    wait_abort();
    `CHK(n > 1589 && n < 1811, 1'h1)
    chk_rd(8'h30, 32'h0000_0002);
    wr(8'h34, 32'h0000_0002);
    @(posedge aclk);
    `CHK(irq, 1'h1)
    wr(8'h30, 32'h0000_0002);
    @(posedge aclk);
    `CHK(irq, 1'h0)
    peer.pulse(5);
    peer.pulse(6);
    wait_abort();
    `CHK(n, 2200)
    wr(8'h04, 32'h0000_0000);
    peer.pulse(5);
    peer.pulse(7);
    wait_abort();
    `CHK(n, 2200)
    chk_rd(8'h38, 32'h0000_0000);
    chk_rd(8'h3C, 32'h0000_0000);
    wr(8'h00, s - 32'h0000_FDE8);
    peer.attach();
    wait_abort();
    `CHK(n > 1589 && n < 1811, 1'h1)
    chk_rd(8'h40, 32'h0000_0010);
    peer.pulse(1);
    chk_rd(8'h40, 32'h0000_0000);
    peer.pulse(4);
    wait_abort();
    `CHK(n, 2200)
    wr(8'h00, s);
    peer.pulse(4);
    peer.pulse(2);
    wait_abort();
    `CHK(n, 2200)
    peer.pulse(4);
    wait_abort();
    `CHK(n > 1589 && n < 1811, 1'h1)
    peer.pulse(4);
    repeat (1000) @(posedge aclk);
    peer.pulse(3);
    wait_abort();
    `CHK(n > 1589 && n < 1811, 1'h1)
    wr(8'h00, 32'h0000_0000);
    peer.attach();
    wait_abort();
    `CHK(n, 2200)
    wr(8'h04, 32'h0000_0001);
    wr(8'h08, 32'h0000_1770);
    wr(8'h24, 32'h0000_0003);
    wr(8'h28, 32'h0000_0002);
    wr(8'h2C, 32'h0000_0001);
    chk_rd(8'h38, 32'h004D_9C98);
    chk_rd(8'h3C, 32'h004D_F5D0);
    peer.pulse(7);
    peer.pulse(9);
    chk_rd(8'h40, 32'h0000_001C);
    peer.pulse(8);
    peer.pulse(10);
    chk_rd(8'h40, 32'h0000_0010);
    peer.len <= 16'h0000;
    chk_rd(8'h3C, 32'h004D_A468);
    `CHK(peer.ka_cnt, 0)
    strb <= 4'h1;
    wr(8'h14, 32'hFFFF_FF00);
    chk_rd(8'h14, 32'h0000_0400);
    wr(8'h38, 32'h0000_0000);
    `CHK(br, 2'h3)
    final_report();
  end
endmodule : tb

/* File: timer_if.sv */
/*
  control and status bundle between the supervisor and one countdown timer.
  assumes the controller drives start, stop and value, the timer the rest.
*/
interface timer_if;
  timeunit 1ns;
  timeprecision 100ps;
  logic start;
  logic stop;
  logic [31:0] value;
  logic expired;
  logic running;

  modport ctl (output start, output stop, output value, input expired, input running);
  modport tmr (input start, input stop, input value, output expired, output running);
endinterface : timer_if

/* File: timer_pkg.sv */
/*
  constants for the serial link timer supervisor: register map, reset values,
  timer indices and timing figures.
  assumes a 200 MHz aclk; all timer arithmetic is in microseconds.
*/
package timer_pkg;

  // ----------------------------------------------------------------
  // clock and time base
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 32'h0000_0005;
  localparam int NS_PER_US = 32'h0000_03E8;
  localparam logic [7:0] CYC_PER_US = 8'(NS_PER_US / CLK_PERIOD_NS);
  localparam logic [31:0] US_PER_MS = 32'h0000_03E8;
  localparam logic [31:0] US_PER_S = 32'h000F_4240;

  // ----------------------------------------------------------------
  // protocol timing figures
  // ----------------------------------------------------------------
  localparam logic [31:0] ATTACH_EXTRA_S = 32'h0000_0041;
  localparam logic [31:0] ATTACH_EXTRA_US = ATTACH_EXTRA_S * US_PER_S;
  localparam logic [31:0] PROC_MAX_S = 32'h0000_0005;
  localparam logic [31:0] PROC_MAX_MS = PROC_MAX_S * US_PER_MS;
  localparam logic [31:0] TURN_MAX_MS = 32'h0000_01F4;
  localparam logic [31:0] BREAK_DEFAULT_MS = 32'h0000_0032;
  localparam logic [31:0] XMIT_DEFAULT_MS = 32'h0000_0000;
  localparam logic [31:0] MPT_CHARS = 32'h0000_0050;

  // ----------------------------------------------------------------
  // configuration register array, word index = byte address / 4
  // ----------------------------------------------------------------
  localparam int NUM_CFG = 12;
  localparam int CFG_IDLE = 0;
  localparam int CFG_ACK = 1;
  localparam int CFG_PROC = 2;
  localparam int CFG_TURN = 3;
  localparam int CFG_XMIT = 4;
  localparam int CFG_CHAR = 5;
  localparam int CFG_BREAK = 6;
  localparam int CFG_PEER_IDLE = 7;
  localparam int CFG_PEER_ACK = 8;
  localparam int CFG_PEER_TURN = 9;
  localparam int CFG_PEER_XMIT = 10;
  localparam int CFG_CTRL = 11;
  localparam int CTRL_NEG_BIT = 0;

  localparam logic [31:0] RST_IDLE_MS = 32'h0000_2710;
  localparam logic [31:0] RST_ACK_MS = 32'h0000_07D0;
  localparam logic [31:0] RST_PROC_MS = 32'h0000_1388;
  localparam logic [31:0] RST_TURN_MS = 32'h0000_0000;
  localparam logic [31:0] RST_CHAR_US = 32'h0000_0412;

  localparam logic [31:0] CFG_RST [NUM_CFG] = '{
    RST_IDLE_MS, RST_ACK_MS, RST_PROC_MS, RST_TURN_MS, XMIT_DEFAULT_MS,
    RST_CHAR_US, BREAK_DEFAULT_MS, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

  // ----------------------------------------------------------------
  // other register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h30;
  localparam logic [7:0] ADDR_MASK = 8'h34;
  localparam logic [7:0] ADDR_MPT = 8'h38;
  localparam logic [7:0] ADDR_BUF = 8'h3C;
  localparam logic [7:0] ADDR_STATE = 8'h40;

  // ----------------------------------------------------------------
  // timers, same order as status and mask bits
  // ----------------------------------------------------------------
  localparam int NUM_TMR = 4;
  localparam int T_IDLE = 0;
  localparam int T_ACK = 1;
  localparam int T_PROC = 2;
  localparam int T_BUF = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage : timer_pkg

/* File: timer_sva_asserts.sv */
/*
  port checker bound to the supervisor top.
  assumes one clock domain, aresetn active low.
*/
module timer_sva_asserts
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // link actions and interrupt
  input wire logic keepalive_req,
  input wire logic abort_req,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic cause_q;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  always_ff @(posedge aclk)
  begin
    cause_q <= abort_req | keepalive_req | s_axi_bvalid;
  end

  // ----
  // properties
  // ----
  property p_abort_pulse; abort_req |=> !abort_req; endproperty
  a_abort_pulse: assert property (p_abort_pulse) else $error("abort held");
  property p_keep_space; keepalive_req |=> !keepalive_req [*8]; endproperty
  a_keep_space: assert property (p_keep_space) else $error("keepalive too close");
  property p_irq_cause; $rose(irq) |-> cause_q || abort_req || keepalive_req; endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
  property p_w_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_awready ##1 s_axi_bvalid;
  endproperty
  a_w_answer: assert property (p_w_answer) else $error("write answer late");
  property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer late");
endmodule : timer_sva_asserts

bind serial_link_timer_supervisor timer_sva_asserts u_sva
(
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .keepalive_req, .abort_req, .irq
);

/* File: us_tick.sv */
/*
  microsecond tick generator.
  assumes aclk at the rate named in the package.
*/
module us_tick
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // tick out
  output logic tick
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] cnt_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= 8'h00;
      tick <= 1'b0;
    end
    else
    begin
      tick <= (cnt_q == timer_pkg::CYC_PER_US - 8'h01);
      cnt_q <= (cnt_q == timer_pkg::CYC_PER_US - 8'h01) ? 8'h00 : cnt_q + 8'h01;
    end
  end

endmodule : us_tick
